/* File: src/lspo_consts.svh */
// Timing counts, a field value and a reset value for the servo interlock.
// Assumes a 10 MHz system clock; included by bare name with a guard.
`ifndef LSPO_CONSTS_SVH
`define LSPO_CONSTS_SVH
// Clock period in nanoseconds.
`define LSPO_CLK_NS 100
// Default polarity detection timeout in microseconds.
`define LSPO_DET_TIMEOUT_US 500000
// Cycles for the timeout, rounded down.
`define LSPO_DET_TIMEOUT_CYC ((`LSPO_DET_TIMEOUT_US * 1000) / `LSPO_CLK_NS)
// Width of the detection timer.
`define LSPO_TMR_W 24
// Stop method field value that selects zero clamp after an overtravel stop.
`define LSPO_STOP_ZCLAMP 2'h1
// Reset value of the held polarity flag.
`define LSPO_POL_RST 1'b0
`endif

/* File: src/lspo_pkg.sv */
// Types shared by the servo interlock and its testbench.
// Assumes the constants header is included by the design files.
package lspo_pkg;
  // Interlock state machine.
  typedef enum logic [2:0] {
    LSPO_OFF,
    LSPO_DETECT,
    LSPO_ON,
    LSPO_FAIL
  } lspo_state_t;

  // Settings that stand still after power-up.
  typedef struct packed {
    logic no_pol_sensor;
    logic abs_encoder;
    logic motorless_test;
    logic [1:0] stop_method;
  } lspo_cfg_t;

  // Drive outputs gathered together.
  typedef struct packed {
    logic servo_enable;
    logic servo_ready;
    logic fwd_inhibit;
    logic rev_inhibit;
    logic motor_stop;
    logic zero_clamp;
    logic base_block;
    logic brake_release_out;
    logic detect_run;
    logic detect_alarm;
  } lspo_out_t;
endpackage : lspo_pkg

/* File: src/lspo_sync.sv */
// Three flip-flop synchroniser for one pin with agreement filter.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module lspo_sync
  import lspo_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_level
);
  // Stage registers; stage one feeds only stage two.
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;

  // Shift the pin in and accept a change when stages two and three agree.
  always_comb begin
    next_stage = {stage[1:0], i_pin};
    next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
  end

  // Register the stages and the filtered level.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stage <= {3{RST_VAL}};
      o_level <= RST_VAL;
    end else begin
      stage <= next_stage;
      o_level <= next_level;
    end
  end
endmodule : lspo_sync

/* File: src/lspo_interlock.sv */
// Servo enable interlock with polarity detection sequencing and overtravel.
// Assumes config ports are steady after reset (power-up acts as reset),
// and that the motor loop reports detection done and failed as pulses.
`timescale 1ns/1ps
`include "lspo_consts.svh"

// How it works
// - Sensorless motor must detect polarity first.
// - Incremental encoder loses polarity at power-up.
// - Absolute encoder keeps stored polarity result.
// - No servo enable until detection completes.
// - Detect only when off, powered, unblocked, unlimited.
// - Any alarm blocks detection except phase mismatch.
// - Motorless test setting must be disabled.
// - Servo-on triggers detection only for incremental.
// - Detection starts with first servo-on command.
// - On incremental completion, ready asserts and servo stays on.
// - Forward limit off means forward drive prohibited.
// - Reverse limit off means reverse drive prohibited.
// - Overtravel forces the motor to stop.
// - Motion away from the limit still allowed.
// - Base block after stop, unless zero clamp.
// - Brake stays released during overtravel stop.
module lspo_interlock
  import lspo_pkg::*;
#(
  parameter int DET_TIMEOUT = `LSPO_DET_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire lspo_cfg_t i_cfg,
  input wire logic i_abs_pol_stored,
  input wire logic i_abs_detect_select_param,
  input wire logic i_servo_on_command,
  input wire logic i_main_power_on,
  input wire logic i_hardwired_base_block,
  input wire logic i_other_alarm,
  input wire logic i_phase_info_mismatch_alarm,
  input wire logic i_detect_done,
  input wire logic i_detect_fail,
  input wire logic i_forward_limit_in,
  input wire logic i_reverse_limit_in,
  input wire logic i_fwd_ref,
  input wire logic i_rev_ref,
  output lspo_out_t o_drive,
  output logic o_pol_valid
);
  // Filtered limit levels, high means motion permitted.
  logic fwd_ok;
  logic rev_ok;
  // Polarity known flag, lost on every reset for incremental encoders.
  logic pol_valid;
  logic next_pol_valid;
  // Interlock state.
  lspo_state_t state;
  lspo_state_t next_state;
  // Detection timeout counter.
  logic [`LSPO_TMR_W-1:0] tmr;
  logic [`LSPO_TMR_W-1:0] next_tmr;
  // Registered outputs.
  lspo_out_t drv;
  lspo_out_t next_drv;
  // Derived conditions.
  logic need_detect;
  logic detect_ok;
  logic detect_trig;
  logic ot_fwd;
  logic ot_rev;
  logic ot_stop;

  // Limit pins arrive from switches, so they are synchronised.
  // Reset value low reads as overtravel until the pins are really sampled.
  lspo_sync #(.RST_VAL(1'b0)) u_fwd_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_forward_limit_in),
    .o_level(fwd_ok)
  );
  lspo_sync #(.RST_VAL(1'b0)) u_rev_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_reverse_limit_in),
    .o_level(rev_ok)
  );

  // Decode detection preconditions and overtravel conditions.
  always_comb begin
    // A low level, such as a broken wire, reads as overtravel.
    ot_fwd = !fwd_ok;
    ot_rev = !rev_ok;
    // Only a sensorless motor without a known polarity needs detection.
    need_detect = i_cfg.no_pol_sensor && !pol_valid;
    // Preconditions; the phase mismatch alarm does not block.
    detect_ok = i_cfg.no_pol_sensor && i_main_power_on
      && !i_hardwired_base_block && !ot_fwd && !ot_rev
      && !i_other_alarm
      && !i_cfg.motorless_test;
    // Servo-on starts it on incremental; absolute uses its own select.
    if (i_cfg.abs_encoder) begin
      detect_trig = i_abs_detect_select_param;
    end else begin
      detect_trig = i_servo_on_command;
    end
    // A stop is forced when the commanded motion runs into a limit.
    ot_stop = (ot_fwd && i_fwd_ref) || (ot_rev && i_rev_ref);
  end

  // Next state, polarity flag, timer and outputs.
  always_comb begin
    next_state = state;
    next_pol_valid = pol_valid;
    next_tmr = tmr;
    next_drv = '0;
    // Absolute encoder restores the stored result; incremental never does.
    if (i_cfg.abs_encoder && i_abs_pol_stored) begin
      next_pol_valid = 1'b1;
    end
    case (state)
      // Servo off: wait for a command.
      LSPO_OFF: begin
        next_tmr = '0;
        if (need_detect) begin
          // Servo is off here, meeting the servo-off precondition.
          if (detect_trig && detect_ok) begin
            next_state = LSPO_DETECT;
          end
        end else if (i_servo_on_command && !i_hardwired_base_block) begin
          next_state = LSPO_ON;
        end
      end
      // Detection running; the motor is powered but not yet ready.
      LSPO_DETECT: begin
        next_drv.detect_run = 1'b1;
        next_drv.brake_release_out = 1'b1;
        next_tmr = tmr + 1'b1;
        if (i_detect_done) begin
          next_pol_valid = 1'b1;
          // On incremental, servo on was the trigger, so it stays on at once.
          if (i_cfg.abs_encoder) begin
            // An absolute run only stores the result; the servo stays off.
            next_state = LSPO_OFF;
            next_drv = '0;
          end else begin
            next_state = LSPO_ON;
            next_drv.servo_enable = 1'b1;
            next_drv.servo_ready = 1'b1;
            next_drv.detect_run = 1'b0;
          end
        end else if (i_detect_fail || i_other_alarm
            || 32'(tmr) >= DET_TIMEOUT - 1) begin
          next_state = LSPO_FAIL;
          next_drv = '0;
          next_drv.detect_alarm = 1'b1;
        end
      end
      // Servo enabled; limits gate the directions.
      LSPO_ON: begin
        next_drv.servo_enable = 1'b1;
        next_drv.servo_ready = 1'b1;
        next_drv.brake_release_out = 1'b1;
        next_drv.fwd_inhibit = ot_fwd;
        next_drv.rev_inhibit = ot_rev;
        if (ot_stop) begin
          next_drv.motor_stop = 1'b1;
          if (i_cfg.stop_method == `LSPO_STOP_ZCLAMP) begin
            next_drv.zero_clamp = 1'b1;
          end else begin
            next_drv.base_block = 1'b1;
          end
        end
        if (!i_servo_on_command || i_hardwired_base_block
            || i_other_alarm || need_detect) begin
          next_state = LSPO_OFF;
          next_drv = '0;
        end
      end
      // Failed detection: servo stays off until servo-on and the absolute select both drop.
      LSPO_FAIL: begin
        next_drv.detect_alarm = 1'b1;
        if (!i_servo_on_command && !i_abs_detect_select_param) begin
          next_state = LSPO_OFF;
          next_drv.detect_alarm = 1'b0;
        end
      end
      default: begin
        next_state = LSPO_OFF;
      end
    endcase
  end

  // Register state; reset models control power-up and drops polarity.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= LSPO_OFF;
      pol_valid <= `LSPO_POL_RST;
      tmr <= '0;
      drv <= '0;
    end else begin
      state <= next_state;
      pol_valid <= next_pol_valid;
      tmr <= next_tmr;
      drv <= next_drv;
    end
  end

  assign o_drive = drv;
  assign o_pol_valid = pol_valid;

  // Checks below watch the registered outputs against the rules.
  // Servo never enabled for a sensorless motor without polarity.
  chk_enable_needs_pol: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (drv.servo_enable && i_cfg.no_pol_sensor) |-> pol_valid)
    else $error("servo enabled without polarity");
  // Completion on incremental gives ready and enable in the on state next cycle.
  chk_done_ready: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_DETECT && i_detect_done && !i_cfg.abs_encoder)
      |=> drv.servo_ready && drv.servo_enable && state == LSPO_ON)
    else $error("ready missing after detection");
  // Detection only entered with preconditions met.
  chk_detect_entry: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_OFF && next_state == LSPO_DETECT)
      |-> (i_main_power_on && !i_hardwired_base_block && fwd_ok && rev_ok))
    else $error("detection started against preconditions");
  // Non mismatch alarm blocks detection start.
  chk_alarm_block: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_OFF && (i_other_alarm || i_cfg.motorless_test))
      |=> state != LSPO_DETECT)
    else $error("detection started with alarm or test mode");
  // Motorless test setting prevents detection.
  chk_motorless: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_DETECT) |-> !$past(i_cfg.motorless_test) ||
      $past(state) == LSPO_DETECT)
    else $error("detection under motorless test");
  // Incremental: only servo-on starts detection.
  chk_trig_source: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_OFF && !i_cfg.abs_encoder && !i_servo_on_command)
      |=> state != LSPO_DETECT)
    else $error("detection without servo-on");
  // Forward limit low inhibits forward drive while on.
  chk_fwd_inhibit: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_ON && next_state == LSPO_ON && !fwd_ok)
      |=> drv.fwd_inhibit && (drv.rev_inhibit == !$past(rev_ok)))
    else $error("forward inhibit wrong");
  // Overtravel stop keeps brake released, picks clamp or base block.
  chk_ot_stop: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    drv.motor_stop |-> drv.brake_release_out
      && (drv.zero_clamp != drv.base_block))
    else $error("overtravel stop outputs wrong");
  // Failure keeps servo off and ready low.
  chk_fail_off: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_FAIL) |-> !drv.servo_enable && !drv.servo_ready)
    else $error("servo on after failed detection");
  // Phase mismatch alarm alone never holds a ready detection back.
  chk_phase_no_block: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_OFF && need_detect && detect_trig
      && i_phase_info_mismatch_alarm && i_main_power_on
      && !i_hardwired_base_block && fwd_ok && rev_ok
      && !i_other_alarm && !i_cfg.motorless_test)
      |=> state == LSPO_DETECT)
    else $error("phase mismatch alarm blocked detection");
  // Reverse limit low inhibits reverse drive while on.
  chk_rev_inhibit: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_ON && next_state == LSPO_ON && !rev_ok)
      |=> drv.rev_inhibit && (drv.fwd_inhibit == !$past(fwd_ok)))
    else $error("reverse inhibit wrong");
  // A reference that runs into an open limit forces a stop.
  chk_stop_forced: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_ON && next_state == LSPO_ON
      && ((!fwd_ok && i_fwd_ref) || (!rev_ok && i_rev_ref)))
      |=> drv.motor_stop && drv.servo_enable)
    else $error("overtravel did not stop the motor");
  // A reference away from the limit is not stopped.
  chk_away_moves: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    (state == LSPO_ON && next_state == LSPO_ON
      && !(!fwd_ok && i_fwd_ref) && !(!rev_ok && i_rev_ref))
      |=> !drv.motor_stop)
    else $error("motion away from the limit was stopped");
  // The stop method setting picks zero clamp or base block.
  chk_stop_method: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    drv.motor_stop
      |-> drv.zero_clamp == (i_cfg.stop_method == `LSPO_STOP_ZCLAMP))
    else $error("stop method not followed");
  // Ready only stands while the interlock is on.
  chk_ready_in_on: assert property (@(posedge i_clk)
    disable iff (i_sys_rst)
    drv.servo_ready |-> state == LSPO_ON)
    else $error("ready outside the on state");
  // Main scenarios worth seeing in a run.
  cov_detect_ok: cover property (@(posedge i_clk)
    state == LSPO_DETECT ##1 state == LSPO_ON);
  cov_detect_fail: cover property (@(posedge i_clk)
    state == LSPO_DETECT ##1 state == LSPO_FAIL);
  cov_ot_stop: cover property (@(posedge i_clk) drv.motor_stop);
  cov_zero_clamp: cover property (@(posedge i_clk) drv.zero_clamp);
  cov_abs_done: cover property (@(posedge i_clk)
    state == LSPO_DETECT && i_detect_done && i_cfg.abs_encoder);
endmodule : lspo_interlock

/* File: sim/lspo_limit_model.sv */
// Far-side model: normally closed limit switches and the motor loop that
// answers a polarity detection run. Assumes the interlock's clock and reset.
`timescale 1ns/1ps
module lspo_limit_model
  import lspo_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_detect_run,
  input wire logic i_fail_mode,
  input wire logic i_fwd_open,
  input wire logic i_rev_open,
  output logic o_detect_done,
  output logic o_detect_fail,
  output logic o_forward_limit,
  output logic o_reverse_limit
);
  // Cycles spent in the current detection run; saturates to pulse once.
  logic [2:0] cnt;
  // One-cycle point where the motor loop reports its outcome.
  logic hit;

  // Normally closed contacts: an open contact or broken wire reads low.
  assign o_forward_limit = !i_fwd_open;
  assign o_reverse_limit = !i_rev_open;

  // The run counter restarts whenever the interlock stops detecting.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_detect_run) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h7) begin
      cnt <= cnt + 3'h1;
    end
  end

  // The outcome is a single pulse, success or failure as commanded.
  assign hit = i_detect_run && (cnt == 3'h5);
  assign o_detect_done = hit && !i_fail_mode;
  assign o_detect_fail = hit && i_fail_mode;
endmodule : lspo_limit_model

/* File: sim/tb_linear_servo_polarity_overtravel.sv */
// Self-checking bench for the servo interlock with a far-side model.
// Assumes a 10 MHz clock; inputs change 5 ns after each rising edge.
`timescale 1ns/1ps
module tb_linear_servo_polarity_overtravel;
  import lspo_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  lspo_cfg_t cfg = '0;
  logic abs_pol = 1'b0, abs_sel = 1'b0, servo_on = 1'b0, pwr = 1'b1;
  logic hardwired_base_block = 1'b0, alarm = 1'b0, phase_alm = 1'b0;
  logic fwd_ref = 1'b0, rev_ref = 1'b0, fail_mode = 1'b0;
  logic fwd_open = 1'b0, rev_open = 1'b0;
  logic done, fail, fwd_lim, rev_lim, pol;
  lspo_out_t drv;
  int n_errors = 0;
  int n_compared = 0;
  int k;

  // Free-running system clock.
  always #50 clk = ~clk;

  lspo_interlock #(.DET_TIMEOUT(50)) i_lspo_interlock (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_cfg(cfg),
    .i_abs_pol_stored(abs_pol), .i_abs_detect_select_param(abs_sel),
    .i_servo_on_command(servo_on), .i_main_power_on(pwr),
    .i_hardwired_base_block(hardwired_base_block), .i_other_alarm(alarm),
    .i_phase_info_mismatch_alarm(phase_alm), .i_detect_done(done),
    .i_detect_fail(fail), .i_forward_limit_in(fwd_lim),
    .i_reverse_limit_in(rev_lim), .i_fwd_ref(fwd_ref), .i_rev_ref(rev_ref),
    .o_drive(drv), .o_pol_valid(pol));

  lspo_limit_model i_lspo_limit_model (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_detect_run(drv.detect_run),
    .i_fail_mode(fail_mode), .i_fwd_open(fwd_open), .i_rev_open(rev_open),
    .o_detect_done(done), .o_detect_fail(fail),
    .o_forward_limit(fwd_lim), .o_reverse_limit(rev_lim));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Compares one output bit with its expected level.
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk

  // Lets n rising edges pass, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  // Power cycle with new settings; limits need a few cycles to settle.
  task automatic restart(input lspo_cfg_t c);
    servo_on = 1'b0;
    abs_sel = 1'b0;
    fail_mode = 1'b0;
    sys_rst = 1'b1;
    cfg = c;
    tick(4);
    sys_rst = 1'b0;
    tick(8);
  endtask : restart

  // Waits a bounded time for run (0), ready (1) or alarm (2) to rise.
  task automatic wait_on(input int w);
    int i;
    for (i = 0; i < 40; i++) begin
      if ((w == 0 ? drv.detect_run : w == 1 ? drv.servo_ready :
           drv.detect_alarm) === 1'b1) break;
      tick(1);
    end
    if (i == 40) begin
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask : wait_on

  // A servo-on request that must not start detection.
  task automatic refused();
    servo_on = 1'b1;
    tick(10);
    chk(drv.detect_run, 1'b0, "detection started");
    servo_on = 1'b0;
    tick(2);
  endtask : refused

  // Main sequence; every restart stands for a power cycle.
  initial begin
    restart('{1'b0, 1'b0, 1'b0, 2'h0});
    refused();
    restart('{1'b1, 1'b0, 1'b1, 2'h0});
    refused();
    restart('{1'b1, 1'b0, 1'b0, 2'h0});
    // Each blocker alone must hold detection off.
    for (k = 0; k < 4; k++) begin
      pwr = (k != 0);
      hardwired_base_block = (k == 1);
      alarm = (k == 2);
      fwd_open = (k == 3);
      tick(6);
      refused();
    end
    fwd_open = 1'b0;
    phase_alm = 1'b1;
    tick(6);
    servo_on = 1'b1;
    wait_on(0);
    chk(drv.servo_enable, 1'b0, "servo on early");
    chk(drv.brake_release_out, 1'b1, "brake held in run");
    wait_on(1);
    chk(drv.servo_enable, 1'b1, "servo not left on");
    chk(pol, 1'b1, "polarity not valid");
    chk(drv.detect_run, 1'b0, "run left on");
    fwd_open = 1'b1;
    fwd_ref = 1'b1;
    tick(8);
    chk(drv.fwd_inhibit, 1'b1, "fwd not inhibited");
    chk(drv.rev_inhibit, 1'b0, "rev inhibited");
    chk(drv.motor_stop, 1'b1, "no stop");
    chk(drv.base_block, 1'b1, "no base block");
    chk(drv.zero_clamp, 1'b0, "clamp wrong");
    chk(drv.brake_release_out, 1'b1, "brake engaged");
    fwd_ref = 1'b0;
    rev_ref = 1'b1;
    tick(2);
    chk(drv.motor_stop, 1'b0, "reverse move stopped");
    fwd_open = 1'b0;
    restart('{1'b1, 1'b0, 1'b0, 2'h1});
    chk(pol, 1'b0, "polarity kept");
    servo_on = 1'b1;
    wait_on(1);
    rev_open = 1'b1;
    tick(8);
    chk(drv.rev_inhibit, 1'b1, "rev not inhibited");
    chk(drv.zero_clamp, 1'b1, "no zero clamp");
    chk(drv.base_block, 1'b0, "base block in clamp");
    rev_open = 1'b0;
    rev_ref = 1'b0;
    restart('{1'b1, 1'b0, 1'b0, 2'h0});
    fail_mode = 1'b1;
    servo_on = 1'b1;
    wait_on(2);
    tick(1);
    chk(drv.servo_enable, 1'b0, "servo on after fail");
    chk(drv.servo_ready, 1'b0, "ready after fail");
    chk(drv.detect_alarm, 1'b1, "no alarm after fail");
    servo_on = 1'b0;
    tick(2);
    chk(drv.detect_alarm, 1'b0, "alarm not cleared");
    // An alarm during a run must fail it as well.
    fail_mode = 1'b0;
    servo_on = 1'b1;
    wait_on(0);
    alarm = 1'b1;
    wait_on(2);
    chk(drv.servo_enable, 1'b0, "servo on after alarm");
    alarm = 1'b0;
    restart('{1'b1, 1'b1, 1'b0, 2'h0});
    refused();
    abs_sel = 1'b1;
    wait_on(0);
    abs_sel = 1'b0;
    abs_pol = 1'b1;
    tick(3);
    chk(pol, 1'b1, "stored polarity lost");
    tick(6);
    chk(drv.detect_run, 1'b0, "absolute run not ended");
    chk(drv.servo_enable, 1'b0, "servo on after absolute run");
    close_out();
  end
endmodule : tb_linear_servo_polarity_overtravel
